// file: design/abio_aux_bits.sv
// Auxiliary output and general-purpose bit I/O command unit.
// Assumes a command parser on the same clock delivering one decoded command
// per cmd_valid_i cycle with the axis selection already resolved, a move
// sequencer that pulses move start and per-axis move end, and a character
// sink for query responses. GPIO inputs come from pins.
//
// Function
// - Aux off drives selected aux lines low.
// - Aux off selects axes like aux on.
// - Aux on releases line; released after reset.
// - Auto power zero: high during move.
// - Auto power nonzero: low during move.
// - Auto power stays armed; aux on/off cancels.
// - All-axes auto power per-parameter axis levels.
// - Armed auto power: move start takes two.
// - Settling delay up to 1000 ms.
// - Zero settling time disables the delay.
// - Active settling: move start takes three.
// - Bit low turns output on, any mode.
// - Bit high turns output off; off at reset.
// - Bit commands act on output bits only.
// - State query: framed six hex, top zero.
// - State bit reads one when line low.
// - Direction query: one output, zero input.
// - Lines 0..7 are inputs by default.
`timescale 1ns/100ps
`include "abio_cfg.svh"

module abio_aux_bits #(
  // Clock cycles in one millisecond; shorten for simulation
  parameter int unsigned CYC_PER_MS = `ABIO_MS_NS / `ABIO_CLK_NS
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Decoded command
  input wire logic cmd_valid_i,
  input abio_pkg::abio_cmd_t cmd_code_i,
  input wire logic [3:0] cmd_axis_sel_i,
  input wire logic [3:0] cmd_param_nz_i,
  input wire logic [11:0] cmd_param_i,
  input wire logic cmd_contour_i,
  output logic cmd_ready_o,
  output logic cmd_reject_o,
  // Move sequencer events
  input wire logic move_start_i,
  input wire logic [3:0] move_end_i,
  output logic [1:0] move_slots_o,
  // Open-collector auxiliary lines, one per axis
  output logic [3:0] aux_o,
  output logic [3:0] aux_oe_o,
  // General-purpose I/O lines
  input wire logic [11:0] gpio_i,
  output logic [11:0] gpio_o,
  output logic [11:0] gpio_oe_o,
  // Direction configuration
  input wire logic dir_wr_i,
  input wire logic [11:0] dir_data_i,
  // Response characters
  output logic [7:0] resp_char_o,
  output logic resp_valid_o,
  input wire logic resp_ready_i
);

  // Sub-millisecond counter width; covers the full default count
  localparam int unsigned SUBW = $clog2(CYC_PER_MS + 1);

  logic [11:0] gpio_meta; // First synchroniser stage, read by gpio_sync only
  logic [11:0] gpio_sync; // Settled pin levels
  logic [11:0] dir; // 1 = output line
  logic [11:0] gpo_on; // 1 = output on (low)
  logic [3:0] aux_low; // 1 = aux line driven low
  logic [3:0] armed; // Auto power armed per axis
  logic [3:0] sense_low; // Auto power drives low during move
  logic [3:0] in_move; // Auto power move under way
  logic [3:0] settling; // Settling delay running after move end
  logic [9:0] settle_ms [4]; // Settling time per axis, ms
  logic [9:0] ms_left [4]; // Whole ms still to wait
  logic [SUBW-1:0] sub_cnt [4]; // Cycles within the current ms
  logic tx_busy; // Response frame in flight
  logic tx_start; // Launch a response
  logic [11:0] tx_value; // Value to frame
  logic accept; // A command is taken this cycle
  logic [1:0] next_slots; // Queue slots for the next move start

  // One-hot select of a bit number; out-of-range numbers select nothing
  function automatic logic [11:0] bit_sel(input logic [11:0] num);
    bit_sel = 12'h000;
    if (num < 12'd12) bit_sel = 12'h001 << num[3:0];
  endfunction : bit_sel

  // Clamp a settling request to the documented ceiling
  function automatic logic [9:0] settle_clamp(input logic [11:0] ms);
    settle_clamp = (ms > {2'b00, `ABIO_SETTLE_MAX_MS}) ? `ABIO_SETTLE_MAX_MS : ms[9:0];
  endfunction : settle_clamp

  // Commands are refused as a whole while a response is being sent
  assign accept = cmd_valid_i && cmd_ready_o;

  // Two-stage synchroniser for the pins
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gpio_meta <= 12'h000;
      gpio_sync <= 12'h000;
    end else begin
      gpio_meta <= gpio_i;
      gpio_sync <= gpio_meta;
    end
  end

  // Direction register; factory setting after reset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dir <= `ABIO_DIR_RST;
    end else if (dir_wr_i) begin
      dir <= dir_data_i;
    end
  end

  // Bit low / bit high; accepted in contouring mode too
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gpo_on <= `ABIO_GPO_ON_RST;
    end else if (accept && cmd_code_i == abio_pkg::CMD_BIT_LOW) begin
      // Input lines are masked out by the direction
      gpo_on <= gpo_on | (bit_sel(cmd_param_i) & dir);
    end else if (accept && cmd_code_i == abio_pkg::CMD_BIT_HIGH) begin
      gpo_on <= gpo_on & ~(bit_sel(cmd_param_i) & dir);
    end
  end

  // Drive the output lines: on is low, off is high; inputs undriven
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      gpio_o <= 12'hfff;
      gpio_oe_o <= 12'h000;
    end else begin
      gpio_o <= ~gpo_on;
      gpio_oe_o <= dir;
    end
  end

  // Per-axis auxiliary, auto power and settling logic
  genvar ax;
  generate
    for (ax = 0; ax < 4; ax++) begin : g_axis
      logic sel; // This axis is named by the command
      logic expire; // Settling ends this cycle
      logic own; // Aux on, aux off or auto power aimed at this axis

      // Single-axis mode gives the current axis, all-axes mode the
      // axes that carried a parameter; the parser resolves both
      assign sel = accept && cmd_axis_sel_i[ax];
      assign expire = settling[ax] && ms_left[ax] == 10'd0 && sub_cnt[ax] == SUBW'(0);
      // Only these codes re-decide the aux level; bit commands and queries that
      // carry an axis selection must not cancel a move in progress
      assign own = sel && (cmd_code_i == abio_pkg::CMD_AUX_ON ||
                           cmd_code_i == abio_pkg::CMD_AUX_OFF ||
                           cmd_code_i == abio_pkg::CMD_AUTO_POWER);

      // Auto power arming; aux on or off disarms the axis
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          armed[ax] <= 1'b0;
          sense_low[ax] <= 1'b0;
        end else if (sel) begin
          unique case (cmd_code_i)
            abio_pkg::CMD_AUTO_POWER: begin
              // Stays armed for all later moves
              armed[ax] <= 1'b1;
              sense_low[ax] <= cmd_param_nz_i[ax];
            end
            abio_pkg::CMD_AUX_ON, abio_pkg::CMD_AUX_OFF: begin
              armed[ax] <= 1'b0;
            end
            default: begin
            end
          endcase
        end
      end

      // Settling time per axis; zero turns the delay off
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          settle_ms[ax] <= 10'd0;
        end else if (sel && cmd_code_i == abio_pkg::CMD_SETTLE_TIME) begin
          settle_ms[ax] <= settle_clamp(cmd_param_i);
        end
      end

      // Move tracking and settling countdown
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          in_move[ax] <= 1'b0;
          settling[ax] <= 1'b0;
          ms_left[ax] <= 10'd0;
          sub_cnt[ax] <= SUBW'(0);
        end else if (!armed[ax] || own) begin
          // Disarming or rearming drops any pending restore
          in_move[ax] <= 1'b0;
          settling[ax] <= 1'b0;
        end else if (move_start_i) begin
          // A new move start overrides a running settling delay
          in_move[ax] <= 1'b1;
          settling[ax] <= 1'b0;
        end else if (in_move[ax] && move_end_i[ax]) begin
          in_move[ax] <= 1'b0;
          if (settle_ms[ax] != 10'd0) begin
            // Count settle_ms full milliseconds before restoring
            settling[ax] <= 1'b1;
            ms_left[ax] <= settle_ms[ax] - 10'd1;
            sub_cnt[ax] <= SUBW'(CYC_PER_MS - 1);
          end
        end else if (settling[ax]) begin
          if (expire) begin
            settling[ax] <= 1'b0;
          end else if (sub_cnt[ax] == SUBW'(0)) begin
            ms_left[ax] <= ms_left[ax] - 10'd1;
            sub_cnt[ax] <= SUBW'(CYC_PER_MS - 1);
          end else begin
            sub_cnt[ax] <= sub_cnt[ax] - SUBW'(1);
          end
        end
      end

      // Auxiliary line level; released after reset
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          aux_low[ax] <= 1'b0;
        end else if (sel && cmd_code_i == abio_pkg::CMD_AUX_ON) begin
          aux_low[ax] <= 1'b0;
        end else if (sel && cmd_code_i == abio_pkg::CMD_AUX_OFF) begin
          aux_low[ax] <= 1'b1;
        end else if (armed[ax] && move_start_i && !own) begin
          // Move level: released for zero, driven low for non-zero
          aux_low[ax] <= sense_low[ax];
        end else if (in_move[ax] && move_end_i[ax] && settle_ms[ax] == 10'd0) begin
          // No delay: complement as soon as the move ends
          aux_low[ax] <= ~sense_low[ax];
        end else if (expire) begin
          aux_low[ax] <= ~sense_low[ax];
        end
      end
    end
  endgenerate

  // Open-collector aux: pin value is always low, enable means drive
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      aux_o <= 4'h0;
      aux_oe_o <= 4'h0;
    end else begin
      aux_o <= 4'h0;
      aux_oe_o <= aux_low;
    end
  end

  // Queue slots a move start costs under the present arming
  always_comb begin
    next_slots = `ABIO_SLOTS_PLAIN;
    for (int i = 0; i < 4; i++) begin
      if (armed[i] && settle_ms[i] != 10'd0) begin
        next_slots = `ABIO_SLOTS_SETTLE;
      end else if (armed[i] && next_slots == `ABIO_SLOTS_PLAIN) begin
        next_slots = `ABIO_SLOTS_AUTO;
      end
    end
  end

  // Publish the slot count for the queue manager
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      move_slots_o <= `ABIO_SLOTS_PLAIN;
    end else begin
      move_slots_o <= next_slots;
    end
  end

  // Queries: state shows low lines as one, direction shows outputs as one
  always_comb begin
    tx_start = 1'b0;
    tx_value = 12'h000;
    if (accept && !cmd_contour_i) begin
      if (cmd_code_i == abio_pkg::CMD_BIT_STATE_QUERY) begin
        tx_start = 1'b1;
        tx_value = ~gpio_sync;
      end else if (cmd_code_i == abio_pkg::CMD_BIT_DIRECTION_QUERY) begin
        tx_start = 1'b1;
        tx_value = dir;
      end
    end
  end

  // Queries are not valid in contouring mode; flag and drop them
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cmd_reject_o <= 1'b0;
    end else begin
      cmd_reject_o <= accept && cmd_contour_i &&
                      (cmd_code_i == abio_pkg::CMD_BIT_STATE_QUERY ||
                       cmd_code_i == abio_pkg::CMD_BIT_DIRECTION_QUERY);
    end
  end

  // Ready falls the cycle after a query is taken and rises the cycle after the frame ends;
  // a second command in that one cycle would be lost, so it is held off here
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cmd_ready_o <= 1'b1;
    end else begin
      cmd_ready_o <= !tx_start && !tx_busy;
    end
  end

  // Framed hex response sender
  abio_hex_tx u_tx (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .start_i(tx_start),
    .value_i(tx_value),
    .busy_o(tx_busy),
    .char_o(resp_char_o),
    .char_valid_o(resp_valid_o),
    .char_ready_i(resp_ready_i)
  );

endmodule : abio_aux_bits

// file: design/abio_hex_tx.sv
// Response sender: frames a twelve-bit value as LF CR, six hex digits, LF CR.
// Assumes a character sink with valid/ready on the same clock.
`timescale 1ns/100ps
`include "abio_cfg.svh"

module abio_hex_tx (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic [11:0] value_i,
  output logic busy_o,
  output logic [7:0] char_o,
  output logic char_valid_o,
  input wire logic char_ready_i
);

  abio_pkg::abio_tx_state_t state; // Sender state
  logic [11:0] value; // Value captured at start
  logic [3:0] idx; // Character position 0..9

  // Character at a frame position; top three digits are always zero
  function automatic logic [7:0] frame_char(input logic [3:0] pos, input logic [11:0] v);
    logic [3:0] nib;
    nib = 4'h0;
    unique case (pos)
      4'h0, 4'h8: frame_char = `ABIO_CHAR_LF;
      4'h1, 4'h9: frame_char = `ABIO_CHAR_CR;
      default: begin
        // Positions 2..4 zero, 5..7 carry the value high nibble first
        if (pos == 4'h5) nib = v[11:8];
        else if (pos == 4'h6) nib = v[7:4];
        else if (pos == 4'h7) nib = v[3:0];
        frame_char = (nib < 4'ha) ? (8'h30 + {4'h0, nib}) : (8'h37 + {4'h0, nib});
      end
    endcase
  endfunction : frame_char

  // Walk the ten characters, one per accepted handshake
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= abio_pkg::TX_IDLE;
      value <= 12'h000;
      idx <= 4'h0;
      busy_o <= 1'b0;
      char_o <= 8'h00;
      char_valid_o <= 1'b0;
    end else begin
      unique case (state)
        abio_pkg::TX_IDLE: begin
          if (start_i) begin
            // First character goes out the cycle after start
            state <= abio_pkg::TX_SEND;
            value <= value_i;
            idx <= 4'h0;
            busy_o <= 1'b1;
            char_o <= frame_char(4'h0, value_i);
            char_valid_o <= 1'b1;
          end
        end
        abio_pkg::TX_SEND: begin
          if (char_ready_i) begin
            if (idx == `ABIO_RESP_LAST) begin
              // Frame done; busy drops with valid
              state <= abio_pkg::TX_IDLE;
              busy_o <= 1'b0;
              char_valid_o <= 1'b0;
            end else begin
              idx <= idx + 4'h1;
              char_o <= frame_char(idx + 4'h1, value);
            end
          end
        end
      endcase
    end
  end

endmodule : abio_hex_tx

// file: shared/abio_cfg.svh
// Constants of the auxiliary and bit I/O command block: widths, reset values,
// timing figures and response framing.
// Assumes a 25 MHz board clock; included by bare name where needed.
`ifndef ABIO_CFG_SVH
`define ABIO_CFG_SVH

// Four axes, twelve general-purpose lines
`define ABIO_NAXES 4
`define ABIO_NBITS 12

// Direction after reset: lines 8..11 outputs, 0..7 inputs
`define ABIO_DIR_RST 12'hf00
// All general-purpose outputs off (high) after reset
`define ABIO_GPO_ON_RST 12'h000

// Clock period and the settling limit, in their own units
`define ABIO_CLK_NS 40
`define ABIO_MS_NS 1000000
`define ABIO_SETTLE_MAX_MS 10'd1000

// Command-queue slots taken by one move start
`define ABIO_SLOTS_PLAIN 2'h1
`define ABIO_SLOTS_AUTO 2'h2
`define ABIO_SLOTS_SETTLE 2'h3

// Response framing characters and length
`define ABIO_CHAR_LF 8'h0a
`define ABIO_CHAR_CR 8'h0d
`define ABIO_RESP_LAST 4'h9

`endif

// file: shared/abio_pkg.sv
// Types of the auxiliary and bit I/O command block.
// Assumes nothing beyond the constants header.
package abio_pkg;

  // Commands handed over by the command parser
  typedef enum logic [3:0] {
    CMD_NONE,
    CMD_AUX_ON,
    CMD_AUX_OFF,
    CMD_AUTO_POWER,
    CMD_SETTLE_TIME,
    CMD_BIT_LOW,
    CMD_BIT_HIGH,
    CMD_BIT_STATE_QUERY,
    CMD_BIT_DIRECTION_QUERY
  } abio_cmd_t;

  // Response sender states
  typedef enum logic {
    TX_IDLE,
    TX_SEND
  } abio_tx_state_t;

endpackage : abio_pkg

// file: tb/abio_aux_bits_bench.sv
// Bench for the aux and bit I/O unit: commands, move events, queries.
// Assumes the host model as far side and a shortened millisecond.
`timescale 1ns/100ps
module abio_aux_bits_bench;
  localparam int unsigned CPM = 4; // Short ms keeps settle waits small
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  abio_pkg::abio_cmd_t cmd_code_i = abio_pkg::CMD_NONE;
  logic [3:0] cmd_axis_sel_i = 4'h0;
  logic [3:0] cmd_param_nz_i = 4'h0;
  logic [11:0] cmd_param_i = 12'h000;
  logic cmd_contour_i = 1'b0;
  logic move_start_i = 1'b0;
  logic [3:0] move_end_i = 4'h0;
  logic dir_wr_i = 1'b0;
  logic [11:0] dir_data_i = 12'h000;
  logic slow = 1'b0; // Sink stalls
  logic [11:0] ext_low = 12'h000; // Grounded inputs
  logic cmd_ready_o, cmd_reject_o, resp_valid_o, resp_ready_i;
  logic [1:0] move_slots_o;
  logic [3:0] aux_o, aux_oe_o;
  logic [11:0] gpio_i, gpio_o, gpio_oe_o;
  logic [7:0] resp_char_o;
  logic [79:0] frame;
  logic [3:0] bn [6] = '{4'ha, 4'h3, 4'hb, 4'hb, 4'hb, 4'hc}; // Bit numbers
  logic [11:0] be [6] = '{12'hbff, 12'hbff, 12'h3ff, 12'hbff, 12'h3ff, 12'h3ff};
  logic [5:0] hi = 6'b001000; // Which table rows are bit high
  int num_errors = 0;
  int checks = 0;
  int rejects = 0;
  always #20 mclk_i = ~mclk_i;
  abio_aux_bits #(.CYC_PER_MS(CPM)) DUT (.mclk_i, .rst_n_i, .cmd_valid_i, .cmd_code_i,
    .cmd_axis_sel_i, .cmd_param_nz_i, .cmd_param_i, .cmd_contour_i, .cmd_ready_o,
    .cmd_reject_o, .move_start_i, .move_end_i, .move_slots_o, .aux_o, .aux_oe_o, .gpio_i,
    .gpio_o, .gpio_oe_o, .dir_wr_i, .dir_data_i, .resp_char_o, .resp_valid_o, .resp_ready_i);
  abio_host_model u_host (.mclk_i, .slow_i(slow), .ext_low_i(ext_low), .drv_i(gpio_o),
    .oe_i(gpio_oe_o), .pin_o(gpio_i), .char_i(resp_char_o), .valid_i(resp_valid_o),
    .ready_o(resp_ready_i), .frame_o(frame));
  // Reject pulses seen
  always @(posedge mclk_i) if (cmd_reject_o === 1'b1) rejects++;
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : wt
  task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One command pulse, then two edges for its effect to reach the pins
  task automatic cmd(input abio_pkg::abio_cmd_t c, input logic [3:0] s,
      input logic [3:0] nz, input logic [11:0] p);
    cmd_code_i = c;
    cmd_axis_sel_i = s;
    cmd_param_nz_i = nz;
    cmd_param_i = p;
    cmd_valid_i = 1'b1;
    wt(1);
    cmd_valid_i = 1'b0;
    wt(2);
  endtask : cmd
  task automatic mv(input logic st, input logic [3:0] en);
    move_start_i = st;
    move_end_i = en;
    wt(1);
    move_start_i = 1'b0;
    move_end_i = 4'h0;
    wt(2);
  endtask : mv
  task automatic dwr(input logic [11:0] v);
    dir_data_i = v;
    dir_wr_i = 1'b1;
    wt(1);
    dir_wr_i = 1'b0;
    wt(2);
  endtask : dwr
  // Query, wait for the frame to finish, compare all ten characters
  task automatic qry(input abio_pkg::abio_cmd_t c, input logic [47:0] hx);
    int n;
    n = 0;
    cmd(c, 4'h1, 4'h0, 12'h000);
    while (cmd_ready_o !== 1'b1 && n < 60) begin
      wt(1);
      n++;
    end
    chk("cmd_ready", 1'b1, cmd_ready_o);
    chk("frame", {16'h0a0d, hx, 16'h0a0d}, frame);
  endtask : qry
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  // Watchdog well beyond the fewer than two hundred cycles the tests need
  initial begin
    #(40 * 2000);
    num_errors++;
    final_report();
  end
  initial begin
    wt(2);
    rst_n_i = 1'b1;
    wt(2);
    chk("aux_oe", 4'h0, aux_oe_o);
    chk("gpio", 12'hfff, gpio_o);
    chk("gpio_oe", 12'hf00, gpio_oe_o);
    chk("slots", 2'h1, move_slots_o);
    $display("test reset done");
    cmd(abio_pkg::CMD_AUX_OFF, 4'h5, 4'h0, 12'h001);
    chk("aux_oe", 4'h5, aux_oe_o);
    cmd(abio_pkg::CMD_AUX_ON, 4'h1, 4'h0, 12'h001);
    chk("aux_oe", 4'h4, aux_oe_o);
    $display("test aux done");
    // First row runs in contouring mode; input and out-of-range bits are ignored
    for (int i = 0; i < 6; i++) begin
      cmd_contour_i = (i == 0);
      cmd(hi[i] ? abio_pkg::CMD_BIT_HIGH : abio_pkg::CMD_BIT_LOW, 4'h1, 4'h0, {8'h00, bn[i]});
      chk("gpio", be[i], gpio_o);
    end
    cmd_contour_i = 1'b0;
    $display("test bits done");
    qry(abio_pkg::CMD_BIT_DIRECTION_QUERY, "000F00");
    dwr(12'h0ff);
    chk("gpio_oe", 12'h0ff, gpio_oe_o);
    qry(abio_pkg::CMD_BIT_DIRECTION_QUERY, "0000FF");
    ext_low = 12'h009;
    dwr(12'hf00);
    wt(2); // New pin levels need two more edges through the synchroniser
    slow = 1'b1;
    qry(abio_pkg::CMD_BIT_STATE_QUERY, "000C09");
    slow = 1'b0;
    cmd_contour_i = 1'b1;
    cmd(abio_pkg::CMD_BIT_STATE_QUERY, 4'h1, 4'h0, 12'h000);
    cmd_contour_i = 1'b0;
    chk("rejects", 1, rejects);
    $display("test queries done");
    cmd(abio_pkg::CMD_AUTO_POWER, 4'h3, 4'h2, 12'h000);
    chk("slots", 2'h2, move_slots_o);
    for (int k = 0; k < 2; k++) begin
      mv(1'b1, 4'h0);
      chk("aux_oe", 4'h6, aux_oe_o);
      // A bit command naming the armed axes mid-move must leave the restore pending
      cmd(abio_pkg::CMD_BIT_HIGH, 4'h3, 4'h0, 12'h00b);
      mv(1'b0, 4'h3);
      chk("aux_oe", 4'h5, aux_oe_o);
    end
    cmd(abio_pkg::CMD_SETTLE_TIME, 4'h1, 4'h0, 12'h002);
    chk("slots", 2'h3, move_slots_o);
    mv(1'b1, 4'h0);
    mv(1'b0, 4'h1);
    chk("aux_oe", 4'h6, aux_oe_o);
    wt(2 * CPM + 2);
    chk("aux_oe", 4'h7, aux_oe_o);
    mv(1'b0, 4'h2);
    wt(2 * CPM + 2);
    chk("aux_oe", 4'h5, aux_oe_o);
    cmd(abio_pkg::CMD_SETTLE_TIME, 4'h1, 4'h0, 12'h000);
    chk("slots", 2'h2, move_slots_o);
    mv(1'b1, 4'h0);
    mv(1'b0, 4'h1);
    chk("aux_oe", 4'h7, aux_oe_o);
    cmd(abio_pkg::CMD_AUX_ON, 4'h3, 4'h0, 12'h000);
    chk("slots", 2'h1, move_slots_o);
    mv(1'b1, 4'h0);
    chk("aux_oe", 4'h4, aux_oe_o);
    $display("test auto power done");
    final_report();
  end
endmodule : abio_aux_bits_bench

// file: tb/abio_aux_bits_checker.sv
// Checker: port-level timing of the aux and bit I/O command unit.
// Assumes one clock and the synchronous active-low reset of the unit.
`timescale 1ns/100ps
module abio_aux_bits_checker #(
  parameter int unsigned CYC_PER_MS = 4
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  input abio_pkg::abio_cmd_t cmd_code_i,
  input wire logic [3:0] cmd_axis_sel_i,
  input wire logic [11:0] cmd_param_i,
  input wire logic cmd_contour_i,
  input wire logic cmd_ready_o,
  input wire logic cmd_reject_o,
  input wire logic [3:0] aux_o,
  input wire logic [3:0] aux_oe_o,
  input wire logic [11:0] gpio_o,
  input wire logic [11:0] gpio_oe_o,
  input wire logic [7:0] resp_char_o,
  input wire logic resp_valid_o,
  input wire logic resp_ready_i
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic is_q; // Either query code
  logic [3:0] bitn; // Bit number field
  assign is_q = cmd_code_i == abio_pkg::CMD_BIT_STATE_QUERY
    || cmd_code_i == abio_pkg::CMD_BIT_DIRECTION_QUERY;
  assign bitn = cmd_param_i[3:0];
  // Command accepted at this edge
  sequence s_take(abio_pkg::abio_cmd_t c);
    cmd_valid_i && cmd_ready_o && cmd_code_i == c;
  endsequence
  // Bit command aimed at an output line
  sequence s_bit(abio_pkg::abio_cmd_t c);
    s_take(c) ##0 (cmd_param_i < 12'h00c && gpio_oe_o[bitn]);
  endsequence
  a_aux_off_low: assert property (s_take(abio_pkg::CMD_AUX_OFF) |-> ##2
    (aux_oe_o & $past(cmd_axis_sel_i, 2)) == $past(cmd_axis_sel_i, 2)) else $error("aux off");
  a_aux_on_release: assert property (s_take(abio_pkg::CMD_AUX_ON) |-> ##2
    (aux_oe_o & $past(cmd_axis_sel_i, 2)) == 4'h0) else $error("aux on");
  a_aux_pull_only: assert property (aux_o == 4'h0) else $error("aux driven high");
  a_bit_low_on: assert property (s_bit(abio_pkg::CMD_BIT_LOW) |-> ##2
    !gpio_o[$past(bitn, 2)]) else $error("bit low");
  a_bit_high_off: assert property (s_bit(abio_pkg::CMD_BIT_HIGH) |-> ##2
    gpio_o[$past(bitn, 2)]) else $error("bit high");
  a_frame_first_lf: assert property (cmd_valid_i && cmd_ready_o && is_q
    && !cmd_contour_i |=> resp_valid_o && resp_char_o == 8'h0a && !cmd_ready_o)
    else $error("frame start");
  a_query_reject: assert property (cmd_valid_i && cmd_ready_o && is_q
    && cmd_contour_i |=> cmd_reject_o ##1 !cmd_reject_o) else $error("reject");
  a_char_held: assert property (resp_valid_o && !resp_ready_i |=>
    resp_valid_o && $stable(resp_char_o)) else $error("char not held");
endmodule : abio_aux_bits_checker

bind abio_aux_bits abio_aux_bits_checker #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.mclk_i,
  .rst_n_i, .cmd_valid_i, .cmd_code_i, .cmd_axis_sel_i, .cmd_param_i, .cmd_contour_i,
  .cmd_ready_o, .cmd_reject_o, .aux_o, .aux_oe_o, .gpio_o, .gpio_oe_o, .resp_char_o,
  .resp_valid_o, .resp_ready_i);

// file: tb/abio_host_model.sv
// Far side: response character sink and the I/O port pins.
// Assumes pull-ups on every line; outside parts may ground inputs.
`timescale 1ns/100ps
module abio_host_model (
  input wire logic mclk_i,
  input wire logic slow_i,
  input wire logic [11:0] ext_low_i,
  input wire logic [11:0] drv_i,
  input wire logic [11:0] oe_i,
  output logic [11:0] pin_o,
  input wire logic [7:0] char_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic [79:0] frame_o
);
  logic ph = 1'b0; // Stall phase
  initial frame_o = '0;
  // Driven value wins, then a grounded input, else the pull-up
  always_comb begin
    for (int i = 0; i < 12; i++) pin_o[i] = oe_i[i] ? drv_i[i] : ~ext_low_i[i];
  end
  // Slow sink accepts every other cycle to stretch the frame
  assign ready_o = slow_i ? ph : 1'b1;
  // Shift in each accepted character
  always @(posedge mclk_i) begin
    ph <= ~ph;
    if (valid_i && ready_o) frame_o <= {frame_o[71:0], char_i};
  end
endmodule : abio_host_model
